/* File: common/spi_cfg_map.vh */
/*
 * Register map and field layout of the SPI configuration block.
 * Assumes a 32-bit AHB-Lite slave; byte address is four times the index.
 */
`ifndef SPI_CFG_MAP_VH
`define SPI_CFG_MAP_VH
`define CTL1_IDX 4'h0
`define CTL2_IDX 4'h1
`define BAUD_IDX 4'h2
`define STAT_IDX 4'h3
`define DATA_IDX 4'h5
`define IRQ_STAT_IDX 4'h8
`define IRQ_MASK_IDX 4'h9
`define CTL1_MASK 8'h73
`define CTL2_MASK 8'h1b
`define BAUD_MASK 8'h77
`define CTL1_RESET 8'h04
`define CTL2_RESET 8'h00
`define BAUD_RESET 8'h00
`define B_EN 6
`define B_MSTR 4
`define B_CPOL 3
`define B_CPHA 2
`define B_SELECT_OUT_ENABLE 1
`define B_LSBF 0
`define B_FAULT_DETECT_ENABLE 4
`define B_BIDIR_OUTPUT_ENABLE 3
`define B_SWAI 1
`define B_SPC 0
`define IRQ_FAULT 0
`define IRQ_DONE 1
`define IRQ_W 2
`define BITS_PER_BYTE 4'h8
`define LAST_EDGE 5'h0f
`define IDX_HI 5
`define IDX_LO 2
`define BAUD_PRE_HI 6
`define BAUD_PRE_LO 4
`define BAUD_SEL_HI 2
`define BAUD_SEL_LO 0
`endif

/* File: rtl/spi_pin_config_baud_gen.v */
/*
 * SPI configuration, pin steering and baud generator with a minimal
 * master shifter, reached over AHB-Lite.
 * Assumes pin inputs are asynchronous; the pad ring resolves the
 * two-way pins from the output enables.
 */
`timescale 1ns/1ps
`include "spi_cfg_map.vh"

module spi_pin_config_baud_gen (
    // Bus clock, reset and freeze
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Power mode
    input wire wait_mode,
    // Serial pins
    input wire ss_n_in,
    output wire ss_n_out,
    output wire ss_n_oe,
    input wire sck_in,
    output wire sck_out,
    output wire sck_oe,
    input wire mosi_in,
    output wire mosi_out,
    output wire mosi_oe,
    input wire miso_in,
    output wire miso_out,
    output wire miso_oe,
    // Interrupt
    output wire irq
);
    // Transfer states. The lead state holds select low for half a serial
    // clock, and the first shift half adds another before the first edge, so the far side sees its data set up
    // well ahead of the first sampling edge.
    localparam ST_IDLE = 2'b00;
    localparam ST_LEAD = 2'b01;
    localparam ST_SHIFT = 2'b10;

    // Configuration, data path and counters; every flop below stops
    // while clk_en is low, so a frozen block resumes where it left off.
    reg [7:0] ctl1_q, ctl2_q, baud_q, data_tx_q, data_rx_q, shift_q;
    reg [1:0] state_q;
    reg [2:0] pre_cnt_q;
    reg [10:0] pow_cnt_q;
    reg sck_q, fault_q, rx_hold_q;
    reg [3:0] bit_cnt_q;
    reg [4:0] edge_cnt_q;
    reg [`IRQ_W-1:0] irq_stat_q, irq_mask_q;
    reg [1:0] ss_sync_q, miso_sync_q, mosi_sync_q;
    reg wr_q;
    reg [3:0] idx_q;
    reg tx_pend_q;

    // Registered address phase; one wait-free data phase
    wire take = hsel & hready & htrans[1];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            idx_q <= 4'h0;
        end else if (clk_en) begin
            wr_q <= take & hwrite;
            // Index only moves on a taken transfer, so the read mux holds
            if (take)
                idx_q <= haddr[`IDX_HI:`IDX_LO];
        end
    end
    // Every register answers in the first data phase, which keeps the
    // bus side down to five flops and no wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Decoded control bits. Reserved bits are masked on write, so these
    // are exactly what software reads back.
    wire master = ctl1_q[`B_MSTR];
    wire enabled = ctl1_q[`B_EN];
    wire fault_detect_enable = ctl2_q[`B_FAULT_DETECT_ENABLE];
    wire select_out_enable = ctl1_q[`B_SELECT_OUT_ENABLE];
    wire spc = ctl2_q[`B_SPC];
    wire bidir_oe = ctl2_q[`B_BIDIR_OUTPUT_ENABLE];
    wire ss_sync = ss_sync_q[1];
    wire rx_bit = spc ? mosi_sync_q[1] : miso_sync_q[1];

    // Synchronisers for asynchronous pin inputs
    // Only the second stage is ever read; the cost is two bus cycles of
    // latency on every sampled level, which bounds the fastest divisor
    // that can still capture incoming data.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ss_sync_q <= 2'b11;
            miso_sync_q <= 2'b00;
            mosi_sync_q <= 2'b00;
        end else if (clk_en) begin
            ss_sync_q <= {ss_sync_q[0], ss_n_in};
            miso_sync_q <= {miso_sync_q[0], miso_in};
            mosi_sync_q <= {mosi_sync_q[0], mosi_in};
        end
    end

    // Data-phase write to one word index
    function wr_hit(input w, input [3:0] cur, input [3:0] want);
        begin
            wr_hit = w & (cur == want);
        end
    endfunction

    // Write decode for the configuration registers
    wire wr_ctl1 = wr_hit(wr_q, idx_q, `CTL1_IDX);
    wire wr_ctl2 = wr_hit(wr_q, idx_q, `CTL2_IDX);
    wire wr_baud = wr_hit(wr_q, idx_q, `BAUD_IDX);
    wire wr_data = wr_hit(wr_q, idx_q, `DATA_IDX);
    wire [7:0] ctl1_new = hwdata[7:0] & `CTL1_MASK;
    wire [7:0] ctl2_new = hwdata[7:0] & `CTL2_MASK;
    wire [7:0] baud_new = hwdata[7:0] & `BAUD_MASK;

    // A change of any bit but SWAI and control one bit 5 while master aborts (bidir output enable only in bidirectional mode), even between frames, where the
    // abort is harmless. The far side sees its frame cut short, so software
    // must bring the remote device back to idle on its own.
    // abort on config change
    wire chg1 = wr_ctl1 & ((ctl1_new[`B_CPOL] != ctl1_q[`B_CPOL]) |
        (ctl1_new[`B_CPHA] != ctl1_q[`B_CPHA]) | (ctl1_new[`B_SELECT_OUT_ENABLE] != select_out_enable) |
        (ctl1_new[`B_LSBF] != ctl1_q[`B_LSBF]));
    wire chg2 = wr_ctl2 & ((ctl2_new[`B_FAULT_DETECT_ENABLE] != fault_detect_enable) |
        (ctl2_new[`B_SPC] != spc));
    wire chgb = wr_baud & (baud_new != baud_q);
    wire chg_oe = wr_ctl2 & spc & (ctl2_new[`B_BIDIR_OUTPUT_ENABLE] != bidir_oe);
    wire fault_evt = master & enabled & fault_detect_enable & ~select_out_enable & ~ss_sync;
    wire abort = (master & (chg1 | chg2 | chgb | chg_oe)) | fault_evt |
        (wr_ctl1 & (ctl1_new[`B_MSTR] != master)) | ~enabled;

    // A mode fault drops master and wins over a same-cycle control one
    // write, so software cannot reclaim the bus as the fault lands.
    // control two and baud writable any time, reserved masked
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl1_q <= `CTL1_RESET;
            ctl2_q <= `CTL2_RESET;
            baud_q <= `BAUD_RESET;
            irq_mask_q <= {`IRQ_W{1'b0}};
        end else if (clk_en) begin
            if (fault_evt)
                ctl1_q[`B_MSTR] <= 1'b0;
            else if (wr_ctl1)
                ctl1_q <= ctl1_new;
            if (wr_ctl2)
                ctl2_q <= ctl2_new;
            if (wr_baud)
                baud_q <= baud_new;
            if (wr_hit(wr_q, idx_q, `IRQ_MASK_IDX))
                irq_mask_q <= hwdata[`IRQ_W-1:0];
        end
    end

    // Two stages: the prescaler counts preselect plus one cycles, the
    // power stage two to the select. Together they make half a serial
    // period, and two halves make the full divisor.
    // divisor from preselect and select
    wire [2:0] presel = baud_q[`BAUD_PRE_HI:`BAUD_PRE_LO];
    wire [2:0] sel = baud_q[`BAUD_SEL_HI:`BAUD_SEL_LO];
    wire [10:0] half_pow = 11'h001 << sel;
    wire gen_run = ~(wait_mode & ctl2_q[`B_SWAI]);
    wire pre_tick = (pre_cnt_q == presel);
    wire half_tick = gen_run & pre_tick & (pow_cnt_q == half_pow - 11'h001);

    // Clearing at idle makes the lead half period exact for every
    // transfer, whatever the counters held when the last one stopped.
    // prescaler, power divider, cleared while idle
    // one toggle per half divisor, so rate is bus clock over divisor
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt_q <= 3'h0;
            pow_cnt_q <= 11'h000;
        end else if (clk_en) begin
            if (state_q == ST_IDLE || abort) begin
                pre_cnt_q <= 3'h0;
                pow_cnt_q <= 11'h000;
            end else if (gen_run) begin
                pre_cnt_q <= pre_tick ? 3'h0 : pre_cnt_q + 3'h1;
                if (pre_tick)
                    pow_cnt_q <= half_tick ? 11'h000 : pow_cnt_q + 11'h001;
            end
        end
    end

    // Clock mode zero framing: data is set before the leading edge, the
    // incoming bit is caught on the leading edge and the shifter moves on
    // the trailing edge, so the outgoing line never changes at the edge
    // on which the far side samples it.
    // Limitation: the pin synchroniser delays the sampled bit by two bus
    // cycles, so a half period under three bus cycles reads stale data;
    // software keeps the divisor at six or more when it receives.
    // bit order select on the shifter
    wire [7:0] shift_nxt = ctl1_q[`B_LSBF] ? {rx_hold_q, shift_q[7:1]} :
        {shift_q[6:0], rx_hold_q};

    // Master transfer engine: half clock lead, then sixteen edges
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            sck_q <= 1'b0;
            shift_q <= 8'h00;
            edge_cnt_q <= 5'h00;
            data_rx_q <= 8'h00;
            data_tx_q <= 8'h00;
            tx_pend_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            rx_hold_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_data) begin
                data_tx_q <= hwdata[7:0]; // top bit stays at seven
                tx_pend_q <= 1'b1;
            end
            if (abort) begin
                state_q <= ST_IDLE;
                sck_q <= 1'b0;
                edge_cnt_q <= 5'h00;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        // A queued byte starts once its write has landed,
                        // so the shifter never loads a byte still on the bus
                        if (master && tx_pend_q && !wr_data) begin
                            shift_q <= data_tx_q;
                            tx_pend_q <= 1'b0;
                            bit_cnt_q <= 4'h0;
                            state_q <= ST_LEAD;
                        end
                    end
                    ST_LEAD: begin
                        if (half_tick)
                            state_q <= ST_SHIFT;
                    end
                    ST_SHIFT: begin
                        if (half_tick) begin
                            sck_q <= ~sck_q;
                            edge_cnt_q <= edge_cnt_q + 5'h01;
                            if (!sck_q) begin
                                rx_hold_q <= rx_bit;
                            end else begin
                                shift_q <= shift_nxt;
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                            if (edge_cnt_q == `LAST_EDGE) begin
                                data_rx_q <= shift_nxt;
                                edge_cnt_q <= 5'h00;
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end
    wire done_evt = (state_q == ST_SHIFT) & half_tick & (edge_cnt_q == `LAST_EDGE) & ~abort;

    // Sticky events; set wins over write-one-to-clear
    // An event and a clear of the same bit can meet in one cycle; the
    // event wins so no completed transfer is lost. The status flag
    // clears on a control one write, never on a read.
    wire clr = wr_hit(wr_q, idx_q, `IRQ_STAT_IDX);
    wire [`IRQ_W-1:0] evt = {done_evt, fault_evt};
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= {`IRQ_W{1'b0}};
            fault_q <= 1'b0;
        end else if (clk_en) begin
            irq_stat_q <= (irq_stat_q & ~(clr ? hwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | evt;
            if (fault_evt)
                fault_q <= 1'b1;
            else if (wr_ctl1)
                fault_q <= 1'b0;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // Read mux; unmapped words read zero
    // No read has a side effect, so a repeated read is always safe.
    always @* begin
        case (idx_q)
            `CTL1_IDX: hrdata = {24'h000000, ctl1_q};
            `CTL2_IDX: hrdata = {24'h000000, ctl2_q};
            `BAUD_IDX: hrdata = {24'h000000, baud_q};
            `STAT_IDX: hrdata = {24'h000000, 3'b000, fault_q, 4'h0};
            `DATA_IDX: hrdata = {24'h000000, data_rx_q};
            `IRQ_STAT_IDX: hrdata = {30'h0, irq_stat_q};
            `IRQ_MASK_IDX: hrdata = {30'h0, irq_mask_q};
            default: hrdata = 32'h00000000;
        endcase
    end

    // Pin steering
    // Nothing is driven while the port is disabled, and a fault drops
    // master so all master outputs release in the same cycle.
    wire active = enabled & (state_q != ST_IDLE);
    assign ss_n_out = ~active;
    // select only driven when master, detect and out enable
    assign ss_n_oe = enabled & master & fault_detect_enable & select_out_enable;
    assign sck_out = sck_q ^ ctl1_q[`B_CPOL];
    assign sck_oe = enabled & master;
    wire tx_bit = ctl1_q[`B_LSBF] ? shift_q[0] : shift_q[7];
    assign mosi_out = tx_bit;
    assign mosi_oe = enabled & master & (~spc | bidir_oe);
    // slave pin use, MISO gated by bidir enable
    assign miso_out = tx_bit;
    assign miso_oe = enabled & ~master & ~ss_sync & (~spc | bidir_oe);
endmodule

/* File: verif/spi_cfg_checker_assertions.sv */
/* Port checker for the SPI config block.
   Assumes clk_en stays high and full-word bus writes. */
`timescale 1ns/1ps
`include "spi_cfg_map.vh"
module spi_cfg_checker (
    // Clock, reset and bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire hreadyout,
    input wire hresp,
    // Pins
    input wire wait_mode,
    input wire ss_n_in,
    input wire ss_n_out,
    input wire ss_n_oe,
    input wire sck_out,
    input wire sck_oe,
    input wire mosi_oe
);
    reg w_q;
    reg [3:0] i_q;
    reg [7:0] c1_q, c2_q, br_q;
    reg [11:0] cnt_q;
    reg p_q, seen_q;
    // Half divisor, in bus cycles
    wire [11:0] half = ({9'h0, br_q[6:4]} + 12'h1) << br_q[2:0];
    wire m = c1_q[`B_EN] && c1_q[`B_MSTR];
    wire bw = w_q && i_q == `BAUD_IDX && (hwdata[7:0] & `BAUD_MASK) != br_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Register mirror; the gap count skips the first edge after a stop, as wait may lag
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_q <= 1'b0;
            i_q <= 4'h0;
            c1_q <= `CTL1_RESET;
            c2_q <= 8'h00;
            br_q <= 8'h00;
            cnt_q <= 12'h000;
            p_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            w_q <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) i_q <= haddr[5:2];
            if (w_q && i_q == `CTL1_IDX) c1_q <= hwdata[7:0] & `CTL1_MASK;
            if (w_q && i_q == `CTL2_IDX) c2_q <= hwdata[7:0] & `CTL2_MASK;
            if (w_q && i_q == `BAUD_IDX) br_q <= hwdata[7:0] & `BAUD_MASK;
            p_q <= sck_out;
            cnt_q <= (ss_n_out || sck_out != p_q) ? 12'h000 : cnt_q + 12'h001;
            seen_q <= (ss_n_out || wait_mode) ? 1'b0 : (sck_out != p_q) | seen_q;
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
    a_ss_output: assert property (m && c2_q[`B_FAULT_DETECT_ENABLE] && c1_q[`B_SELECT_OUT_ENABLE] |-> ##[0:1] ss_n_oe)
        else $error("select not driven");
    a_ss_unused: assert property ((c1_q[`B_MSTR] && !(c2_q[`B_FAULT_DETECT_ENABLE] && c1_q[`B_SELECT_OUT_ENABLE]))[*2]
        |-> !ss_n_oe) else $error("select driven");
    a_ss_slave: assert property ((!c1_q[`B_MSTR])[*2] |-> !ss_n_oe)
        else $error("slave drives select");
    a_mosi_use: assert property (sck_oe |-> mosi_oe == (!c2_q[`B_SPC] || c2_q[`B_BIDIR_OUTPUT_ENABLE]))
        else $error("mosi buffer wrong");
    a_fault_off: assert property (m && c2_q[`B_FAULT_DETECT_ENABLE] && !c1_q[`B_SELECT_OUT_ENABLE] && !ss_n_in
        |-> ##[1:6] !sck_oe && !mosi_oe) else $error("fault kept outputs");
    a_sck_rate: assert property (seen_q && sck_out != p_q && !ss_n_out && sck_oe
        |-> cnt_q == half - 12'h001) else $error("sck half period wrong");
    a_wait_hold: assert property ((wait_mode && c2_q[`B_SWAI])[*3] |-> $stable(sck_out))
        else $error("sck ran in wait");
    a_abort_idle: assert property (bw && !ss_n_out && sck_oe |-> ##[1:3] ss_n_out)
        else $error("baud change kept transfer");
endmodule
bind spi_pin_config_baud_gen spi_cfg_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .wait_mode(wait_mode),
    .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_oe(mosi_oe));

/* File: verif/spi_periph_model.sv */
/* Far-side SPI peripheral, clock mode 0.
   Assumes the bench resolves the select and data wires. */
`timescale 1ns/1ps
module spi_periph_model (
    // Wires from the port
    input wire sck,
    input wire ss_n,
    input wire mosi,
    // Setup from the bench
    input wire lsbf,
    input wire [7:0] tx,
    // Far side
    output reg miso,
    output reg [7:0] rx
);
    integer n = 0;
    initial miso = 1'b1;
    initial rx = 8'h00;
    always @(negedge ss_n) begin
        n = 0;
        miso = lsbf ? tx[0] : tx[7];
    end
    always @(posedge sck) begin
        if (!ss_n) rx = lsbf ? {mosi, rx[7:1]} : {rx[6:0], mosi};
        n = n + 1;
    end
    // Next bit on the trailing edge
    always @(negedge sck) if (!ss_n && n < 8) miso = lsbf ? tx[n] : tx[7 - n];
    // Released line shows the inverse so a stale bit cannot pass
    always @(posedge ss_n) miso = ~miso;
endmodule

/* File: verif/tb_top.sv */
/* Self-checking bench for the SPI config block.
   Assumes a zero-wait slave; pull-ups on select and mosi. */
`timescale 1ns/1ps
`include "spi_cfg_map.vh"
module tb_top;
    reg hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, wait_mode = 1'b0, ss_drv = 1'b1, lsbf = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, r, b;
    reg [7:0] tx = 8'h00, d;
    wire hreadyout, hresp, irq, ss_n_out, ss_n_oe, sck_out, sck_oe, mosi_out, mosi_oe;
    wire miso_out, miso_oe, pm;
    wire [31:0] hrdata;
    wire [7:0] prx;
    integer fails = 0, cmp_count = 0, seed = 30, i;
    // Wire levels resolved from every driver
    wire ss_w = ss_n_oe ? ss_n_out : ss_drv;
    wire mosi_w = mosi_oe ? mosi_out : 1'b1;
    wire miso_w = miso_oe ? miso_out : pm;
    initial begin
        forever #50 hclk = ~hclk;
    end
    spi_pin_config_baud_gen DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .wait_mode(wait_mode), .ss_n_in(ss_w), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe),
        .sck_in(1'b0), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe(miso_oe), .irq(irq));
    spi_periph_model peer (.sck(sck_out), .ss_n(ss_w), .mosi(mosi_w), .lsbf(lsbf), .tx(tx),
        .miso(pm), .rx(prx));
    task conclude;
        begin
            $display("fails %0d cmp_count %0d", fails, cmp_count);
            if (fails == 0 && cmp_count > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            cmp_count++;
            if (g !== e) begin
                fails++;
                $display("wrong value %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // One AHB single transfer; read data taken at the data-phase edge
    task bus(input w, input [31:0] a, input [31:0] dd);
        integer t;
        begin
            @(posedge hclk);
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            t = 0;
            do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 50);
            htrans <= 2'h0;
            hwdata <= dd;
            do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 100);
            r = hrdata;
            if (t >= 100) begin fails++; conclude; end
        end
    endtask
    task await_ss(input v, input integer lim);
        integer t;
        begin
            for (t = 0; ss_n_out !== v; t++) begin
                if (t > lim) begin fails++; conclude; end
                @(posedge hclk);
            end
            #1;
        end
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, 32'h0, 0); chk("ctl1 reset", {24'h0, `CTL1_RESET}, r);
        bus(0, 32'h4, 0); chk("ctl2 reset", {24'h0, `CTL2_RESET}, r);
        bus(0, 32'h1c, 0); chk("unmapped", 32'h0, r);
        bus(1, 32'h4, 32'hff); bus(0, 32'h4, 0); chk("ctl2 mask", 32'h1b, r);
        bus(1, 32'h8, 32'hff); bus(0, 32'h8, 0); chk("baud mask", 32'h77, r);
        // Every master/slave, fault detect and select-out combination
        for (i = 0; i < 8; i++) begin
            bus(1, 32'h4, i[1] ? 32'h10 : 32'h0);
            bus(1, 32'h0, 32'h40 | (i[2] ? 32'h10 : 0) | (i[0] ? 32'h2 : 0));
            @(posedge hclk); #1 chk("ss oe", i[2] & i[1] & i[0], ss_n_oe);
        end
        // Transfers with random data, random baud except the last, alternating bit order; the last one sits in stopped wait
        for (i = 0; i < 6; i++) begin
            lsbf = i[0];
            tx = $random(seed);
            d = $random(seed);
            b = (i == 5) ? 32'h11 : (32'h11 | ($random(seed) & 32'h22));
            bus(1, 32'h8, b); bus(1, 32'h4, (i == 5) ? 32'h12 : 32'h10);
            bus(1, 32'h0, 32'h52 | lsbf); bus(1, 32'h14, {24'h0, d});
            await_ss(0, 20);
            if (i == 5) begin repeat (6) @(posedge hclk); wait_mode <= 1'b1; end
            if (i == 5) begin repeat (40) @(posedge hclk); wait_mode <= 1'b0; end
            await_ss(1, 5000); chk("sent", d, prx);
            bus(0, 32'h14, 0); chk("received", tx, r);
        end
        bus(1, 32'h8, 32'h77); bus(1, 32'h14, 32'h5a); await_ss(0, 20);
        bus(1, 32'h8, 32'h00); await_ss(1, 5); chk("abort", 1, ss_n_out);
        bus(1, 32'h4, 32'h19); #1 chk("bidir out", 1, mosi_oe);
        bus(1, 32'h4, 32'h11); #1 chk("bidir in", 0, mosi_oe);
        // Slave setup keeps a baud other than divide by two
        bus(1, 32'h8, 32'h11); bus(1, 32'h0, 32'h40); bus(1, 32'h4, 32'h19);
        #1 chk("slave mosi", 0, mosi_oe);
        @(posedge hclk); ss_drv <= 1'b0; repeat (3) @(posedge hclk);
        #1 chk("slave miso", 1, miso_oe);
        @(posedge hclk); ss_drv <= 1'b1; repeat (3) @(posedge hclk);
        #1 chk("slave miso off", 0, miso_oe);
        bus(1, 32'h20, 32'h3); bus(1, 32'h24, 32'h1); bus(1, 32'h4, 32'h10);
        bus(1, 32'h0, 32'h50); ss_drv <= 1'b0; repeat (6) @(posedge hclk);
        #1 chk("irq", 1, irq);
        bus(0, 32'hc, 0); chk("fault flag", 32'h10, r & 32'h10);
        ss_drv <= 1'b1; bus(1, 32'h20, 32'h1); #1 chk("irq clear", 0, irq);
        bus(1, 32'h24, 32'h0); bus(1, 32'h0, 32'h50); ss_drv <= 1'b0;
        repeat (6) @(posedge hclk); #1 chk("irq masked", 0, irq);
        bus(0, 32'h20, 0); chk("irq status", 32'h1, r & 32'h1);
        conclude;
    end
endmodule
